/* fsc_pkg.sv */
// package: register map, field layout and types of the fiber/SGMII control block
package fsc_pkg;

  // printed offsets are register indices; byte address is four times the index
  localparam logic [11:0] FSC_IDX_LINK_LOSS = 12'h1EC;
  localparam logic [11:0] FSC_IDX_FIBER_CONTROL = 12'hC00;
  localparam logic [11:0] FSC_IDX_FIBER_STATUS = 12'hC01;
  localparam logic [11:0] FSC_IDX_MODE_CFG = 12'hC10;
  localparam logic [13:0] FSC_ADDR_LINK_LOSS = {FSC_IDX_LINK_LOSS, 2'b00};
  localparam logic [13:0] FSC_ADDR_FIBER_CONTROL = {FSC_IDX_FIBER_CONTROL, 2'b00};
  localparam logic [13:0] FSC_ADDR_FIBER_STATUS = {FSC_IDX_FIBER_STATUS, 2'b00};
  localparam logic [13:0] FSC_ADDR_MODE_CFG = {FSC_IDX_MODE_CFG, 2'b00};

  localparam logic [15:0] FSC_RST_LINK_LOSS = 16'h1FFD;
  localparam logic [15:0] FSC_RST_FIBER_CONTROL = 16'h1140;
  localparam logic [15:0] FSC_RST_FIBER_STATUS = 16'h6149;
  localparam logic [15:0] FSC_STS_FIXED_MASK = 16'hFFDB;

  // register field positions
  localparam int FSC_B_LL_DIS = 0;
  localparam int FSC_B_RESET = 15;
  localparam int FSC_B_LOOP = 14;
  localparam int FSC_B_SPD_LO = 13;
  localparam int FSC_B_AN_EN = 12;
  localparam int FSC_B_PWRDN = 11;
  localparam int FSC_B_ISO = 10;
  localparam int FSC_B_AN_RST = 9;
  localparam int FSC_B_DUPLEX = 8;
  localparam int FSC_B_COLTEST = 7;
  localparam int FSC_B_SPD_HI = 6;
  localparam int FSC_B_STS_AN_DONE = 5;
  localparam int FSC_B_STS_LINK = 2;
  localparam int FSC_B_BRIDGE_DIR = 0;

  // countdown loaded on a soft reset request; fiber logic is held in reset for one cycle more than this
  localparam logic [3:0] FSC_SOFT_RST_CYCLES = 4'hF;
  // cycles after reset release before synchronised straps are valid
  localparam logic [1:0] FSC_STRAP_SETTLE = 2'h2;

  localparam logic [1:0] FSC_RESP_OKAY = 2'b00;
  localparam logic [1:0] FSC_RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    FSC_SPD_10 = 2'h0,
    FSC_SPD_100 = 2'h1,
    FSC_SPD_1000 = 2'h2,
    FSC_SPD_RSVD = 2'h3
  } fsc_speed_t;

  // boot-time configuration straps
  typedef struct packed {
    logic speedLow;
    logic speedHigh;
    logic autonegEnable;
  } fsc_strap_t;

  // controls driven towards the PCS and MAC interface
  typedef struct packed {
    logic fiberLogicReset;
    logic macSideLoopback;
    fsc_speed_t linkSpeed;
    logic autonegEnable;
    logic autonegRestart;
    logic serdesPowerDown;
    logic macIsolate;
    logic forcedDuplex;
    logic collisionTest;
    logic sgmiiForcedSpeedHigh;
    logic linkLossEnable;
    logic sgmiiToRgmiiBridge;
  } fsc_ctrl_t;

  // live PCS status
  typedef struct packed {
    logic linkUp;
    logic autonegDone;
    logic autonegBusy;
  } fsc_pcs_sts_t;

endpackage

/* fsc_sync2.sv */
// module: two-flop synchroniser for a vector of pin levels
`timescale 1ns/100ps
`default_nettype none
module fsc_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } fsc_sync_state_t;

  fsc_sync_state_t state_q;
  fsc_sync_state_t state_d;

  always_comb begin
    state_d.stage1 = pinIn;
    state_d.stage2 = state_q.stage1;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign syncOut = state_q.stage2;

endmodule
`default_nettype wire

/* fsc_fiber_sgmii_ctrl.sv */
// module: fiber/SGMII control registers with AXI4-Lite slave
//
// Functional notes
// - link-loss action enabled when disable bit is 0; resets to 1
// - writing reset bit resets fiber logic; bit self-clears on completion
// - bit 14 enables MAC-side loopback in fiber and bridge modes
// - two-bit speed code from bits 13 and 6 selects 10/100/1000
// - both speed bits take their reset values from straps
// - bit 12 enables autonegotiation; reset value from strap
// - bit 11 powers down SGMII; it does not assert the fiber logic reset
// - bit 10 isolates the MAC interface
// - isolate ignored in SGMII-to-RGMII bridge direction
// - writing 1 to bit 9 restarts autonegotiation while bit 12 enables it; self-clears
// - bit 8 forces duplex, only in MII-to-100FX; resets full
// - collision test echoes transmit enable onto collision, except while bit 11 powers down
// - speed MSB forces SGMII speed only while autonegotiation is off
// - one register set shared by fiber, both bridges, media converter
// - bridge direction bit: 0 RGMII-to-SGMII, 1 SGMII-to-RGMII
`timescale 1ns/100ps
`default_nettype none
module fsc_fiber_sgmii_ctrl
  import fsc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic [13:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [13:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // straps and PCS side
  input wire fsc_strap_t strapPins,
  input wire fsc_pcs_sts_t pcsStatus,
  input wire logic miiFxMode,
  input wire logic macTxEnable,
  output fsc_ctrl_t ctrlOut,
  output logic duplexFull,
  output logic collisionOut
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic strapLoaded;
    logic [1:0] strapWait;
    logic [15:0] linkLoss;
    logic [15:0] fxCtrl;
    logic bridgeDir;
    logic [3:0] softRstCnt;
    logic anRestartPulse;
    logic awTaken;
    logic [13:0] awAddr;
    logic wTaken;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic awRdy;
    logic wRdy;
    logic arRdy;
    fsc_ctrl_t ctrl;
    logic duplexFull;
    logic collision;
  } fsc_state_t;

  fsc_state_t state_q;
  fsc_state_t state_d;
  fsc_strap_t strapSync;
  fsc_pcs_sts_t pcsSync;
  logic [1:0] miscSync;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  fsc_sync2 #(.WIDTH($bits(fsc_strap_t))) u_strap_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pinIn(strapPins),
    .syncOut(strapSync)
  );

  fsc_sync2 #(.WIDTH($bits(fsc_pcs_sts_t))) u_pcs_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pinIn(pcsStatus),
    .syncOut(pcsSync)
  );

  fsc_sync2 #(.WIDTH(2)) u_misc_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pinIn({miiFxMode, macTxEnable}),
    .syncOut(miscSync)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [15:0] wVal;
    logic [15:0] stsVal;
    logic doWrite;
    logic doRead;
    logic anActive;
    logic rstStart;
    wVal = 16'h0000;
    stsVal = 16'h0000;
    doWrite = 1'b0;
    doRead = 1'b0;
    anActive = 1'b0;
    rstStart = 1'b0;
    state_d = state_q;
    state_d.anRestartPulse = 1'b0;

    // strap capture
    // synchroniser is cleared by reset: wait until it shows the pins
    // before taking the strapped bits, once per reset
    if (!state_q.strapLoaded) begin
      if (state_q.strapWait == FSC_STRAP_SETTLE) begin
        state_d.strapLoaded = 1'b1;
        state_d.fxCtrl[FSC_B_SPD_LO] = strapSync.speedLow;
        state_d.fxCtrl[FSC_B_SPD_HI] = strapSync.speedHigh;
        state_d.fxCtrl[FSC_B_AN_EN] = strapSync.autonegEnable;
      end else begin
        state_d.strapWait = state_q.strapWait + 2'h1;
      end
    end

    // AXI write channels, accepted in either order
    if (s_axi_awvalid && s_axi_awready) begin
      state_d.awTaken = 1'b1;
      state_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_d.wTaken = 1'b1;
      state_d.wData = s_axi_wdata;
      state_d.wStrb = s_axi_wstrb;
    end
    doWrite = state_q.awTaken && state_q.wTaken && !state_q.bValid;
    if (s_axi_bvalid && s_axi_bready) begin
      state_d.bValid = 1'b0;
    end

    if (doWrite) begin
      state_d.awTaken = 1'b0;
      state_d.wTaken = 1'b0;
      state_d.bValid = 1'b1;
      state_d.bResp = FSC_RESP_OKAY;
      wVal = state_q.wData[15:0];
      case ({state_q.awAddr[13:2], 2'b00})
        FSC_ADDR_LINK_LOSS: begin
          // link-loss disable
          // reserved bits are stored as written
          if (state_q.wStrb[0]) begin
            state_d.linkLoss[7:0] = wVal[7:0];
          end
          if (state_q.wStrb[1]) begin
            state_d.linkLoss[15:8] = wVal[15:8];
          end
        end
        FSC_ADDR_FIBER_CONTROL: begin
          if (state_q.wStrb[0]) begin
            state_d.fxCtrl[7:0] = wVal[7:0];
          end
          if (state_q.wStrb[1]) begin
            state_d.fxCtrl[15:8] = wVal[15:8];
            state_d.anRestartPulse = wVal[FSC_B_AN_RST];
            // soft reset start
            // a new request reloads the count even mid-reset
            if (wVal[FSC_B_RESET]) begin
              state_d.softRstCnt = FSC_SOFT_RST_CYCLES;
              rstStart = 1'b1;
            end
          end
        end
        FSC_ADDR_FIBER_STATUS: begin
          state_d.bResp = FSC_RESP_SLVERR;
        end
        FSC_ADDR_MODE_CFG: begin
          if (state_q.wStrb[0]) begin
            state_d.bridgeDir = wVal[FSC_B_BRIDGE_DIR];
          end
        end
        default: begin
          state_d.bResp = FSC_RESP_SLVERR;
        end
      endcase
    end

    // soft reset countdown and self-clear
    // count stands still in the cycle that loads it
    if (!rstStart) begin
      if (state_q.softRstCnt != 4'h0) begin
        state_d.softRstCnt = state_q.softRstCnt - 4'h1;
      end else begin
        state_d.fxCtrl[FSC_B_RESET] = 1'b0;
      end
    end
    if (state_q.anRestartPulse) begin
      state_d.fxCtrl[FSC_B_AN_RST] = 1'b0;
    end

    // status view: fixed bits plus live link and autoneg state
    stsVal = FSC_RST_FIBER_STATUS & FSC_STS_FIXED_MASK;
    stsVal[FSC_B_STS_LINK] = pcsSync.linkUp;
    stsVal[FSC_B_STS_AN_DONE] = pcsSync.autonegDone;

    // AXI read channel
    doRead = s_axi_arvalid && s_axi_arready;
    if (s_axi_rvalid && s_axi_rready) begin
      state_d.rValid = 1'b0;
    end
    if (doRead) begin
      state_d.rValid = 1'b1;
      state_d.rResp = FSC_RESP_OKAY;
      // low address bits ignored: every register is one aligned word
      case ({s_axi_araddr[13:2], 2'b00})
        FSC_ADDR_LINK_LOSS: begin
          state_d.rData = {16'h0000, state_q.linkLoss};
        end
        FSC_ADDR_FIBER_CONTROL: begin
          state_d.rData = {16'h0000, state_q.fxCtrl};
        end
        FSC_ADDR_FIBER_STATUS: begin
          state_d.rData = {16'h0000, stsVal};
        end
        FSC_ADDR_MODE_CFG: begin
          state_d.rData = {31'h00000000, state_q.bridgeDir};
        end
        default: begin
          state_d.rData = 32'h00000000;
          state_d.rResp = FSC_RESP_SLVERR;
        end
      endcase
    end

    // ****************************************************************
    // controls towards PCS and MAC interface
    // ****************************************************************
    anActive = state_q.fxCtrl[FSC_B_AN_EN];
    state_d.ctrl.fiberLogicReset = state_q.fxCtrl[FSC_B_RESET] || (state_q.softRstCnt != 4'h0);
    state_d.ctrl.macSideLoopback = state_q.fxCtrl[FSC_B_LOOP];
    state_d.ctrl.linkSpeed = fsc_speed_t'({state_q.fxCtrl[FSC_B_SPD_HI],
                                          state_q.fxCtrl[FSC_B_SPD_LO]});
    state_d.ctrl.autonegEnable = anActive;
    state_d.ctrl.autonegRestart = state_q.anRestartPulse && anActive;
    state_d.ctrl.serdesPowerDown = state_q.fxCtrl[FSC_B_PWRDN];
    state_d.ctrl.macIsolate = state_q.fxCtrl[FSC_B_ISO] && !state_q.bridgeDir;
    state_d.ctrl.forcedDuplex = state_q.fxCtrl[FSC_B_DUPLEX];
    state_d.ctrl.collisionTest = state_q.fxCtrl[FSC_B_COLTEST];
    state_d.ctrl.sgmiiForcedSpeedHigh = state_q.fxCtrl[FSC_B_SPD_HI] && !anActive;
    // link loss enabled when bit is 0
    state_d.ctrl.linkLossEnable = !state_q.linkLoss[FSC_B_LL_DIS];
    state_d.ctrl.sgmiiToRgmiiBridge = state_q.bridgeDir;
    state_d.duplexFull = miscSync[1] ? state_q.fxCtrl[FSC_B_DUPLEX] : 1'b1;
    state_d.collision = state_q.fxCtrl[FSC_B_COLTEST] && miscSync[0] &&
                        !state_q.fxCtrl[FSC_B_PWRDN];

    // readies registered from the next state, so each port is a flop
    // and still drops in the same cycle as the combined form would
    state_d.awRdy = !state_d.awTaken && !state_d.bValid;
    state_d.wRdy = !state_d.wTaken && !state_d.bValid;
    state_d.arRdy = !state_d.rValid;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= '0;
      state_q.linkLoss <= FSC_RST_LINK_LOSS;
      state_q.fxCtrl <= FSC_RST_FIBER_CONTROL;
      state_q.ctrl.forcedDuplex <= 1'b1;
      state_q.ctrl.linkLossEnable <= 1'b0;
      state_q.duplexFull <= 1'b1;
      state_q.awRdy <= 1'b1;
      state_q.wRdy <= 1'b1;
      state_q.arRdy <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign s_axi_awready = state_q.awRdy;
  assign s_axi_wready = state_q.wRdy;
  assign s_axi_bvalid = state_q.bValid;
  assign s_axi_bresp = state_q.bResp;
  assign s_axi_arready = state_q.arRdy;
  assign s_axi_rvalid = state_q.rValid;
  assign s_axi_rdata = state_q.rData;
  assign s_axi_rresp = state_q.rResp;
  assign ctrlOut = state_q.ctrl;
  assign duplexFull = state_q.duplexFull;
  assign collisionOut = state_q.collision;

endmodule
`default_nettype wire

/* fsc_checker.sv */
// checker: bus and control assertions for the fiber control block
`timescale 1ns/100ps
`default_nettype none
module fsc_checker
  import fsc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire fsc_ctrl_t ctrlOut,
  input wire logic collisionOut
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_wr_resp; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  property p_wr_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write taken while busy");
  property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_done: assert property (p_b_done) else $error("write answer repeated");
  property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  property p_ar_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_busy: assert property (p_ar_busy) else $error("read taken while busy");
  property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_done: assert property (p_r_done) else $error("read answer repeated");
  property p_restart; ctrlOut.autonegRestart |=> !ctrlOut.autonegRestart; endproperty
  a_restart: assert property (p_restart) else $error("restart not a pulse");
  property p_softrst; $rose(ctrlOut.fiberLogicReset) |=> ctrlOut.fiberLogicReset [*8]; endproperty
  a_softrst: assert property (p_softrst) else $error("fiber reset too short");
  property p_iso; ctrlOut.sgmiiToRgmiiBridge |-> !ctrlOut.macIsolate; endproperty
  a_iso: assert property (p_iso) else $error("isolate in bridge");
  property p_col; collisionOut |-> ctrlOut.collisionTest || $past(ctrlOut.collisionTest); endproperty
  a_col: assert property (p_col) else $error("collision without test");
  c_restart: cover property (ctrlOut.autonegRestart);
  c_col: cover property (collisionOut);
  c_softrst: cover property ($rose(ctrlOut.fiberLogicReset));
endmodule
bind fsc_fiber_sgmii_ctrl fsc_checker u_chk (.mclk(mclk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .ctrlOut(ctrlOut), .collisionOut(collisionOut));
`default_nettype wire

/* fsc_pcs_model.sv */
// partner: pcs and mac side model
`timescale 1ns/100ps
`default_nettype none
module fsc_pcs_model
  import fsc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic linkReq,
  input wire logic txReq,
  input wire fsc_ctrl_t ctrlIn,
  output fsc_pcs_sts_t pcsStatus,
  output logic macTxEnable
);
  logic [4:0] anCnt_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) anCnt_q <= 5'h00;
    else if (ctrlIn.autonegRestart) anCnt_q <= 5'h14;
    else if (anCnt_q != 5'h00) anCnt_q <= anCnt_q - 5'h01;
  end
  assign pcsStatus.linkUp = linkReq && !ctrlIn.serdesPowerDown && !ctrlIn.fiberLogicReset;
  assign pcsStatus.autonegBusy = anCnt_q != 5'h00;
  assign pcsStatus.autonegDone = pcsStatus.linkUp && ctrlIn.autonegEnable && anCnt_q == 5'h00;
  assign macTxEnable = txReq;
endmodule
`default_nettype wire

/* fiber_sgmii_control_regs_test.sv */
// testbench: fiber control register block
`timescale 1ns/100ps
`default_nettype none
module fiber_sgmii_control_regs_test;
  import fsc_pkg::*;
  logic mclk, rst_n, awValid, wValid, bReady, arValid, rReady, miiFxMode, linkReq, txReq;
  logic awReady, wReady, bValid, arReady, rValid, macTxEnable, duplexFull, collisionOut, br;
  logic [13:0] awAddr, arAddr;
  logic [31:0] wData, rData;
  logic [3:0] wStrb;
  logic [1:0] bResp, rResp;
  logic [15:0] v;
  logic [15:0] corner [4] = '{16'h0400, 16'h2400, 16'h0440, 16'h3440};
  fsc_strap_t strapPins;
  fsc_pcs_sts_t pcsStatus;
  fsc_ctrl_t ctrlOut;
  int miscompares = 0, checks = 0, restarts = 0, resetCycles = 0, r0;
  fsc_fiber_sgmii_ctrl dut (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .strapPins(strapPins), .pcsStatus(pcsStatus), .miiFxMode(miiFxMode),
    .macTxEnable(macTxEnable), .ctrlOut(ctrlOut), .duplexFull(duplexFull),
    .collisionOut(collisionOut));
  fsc_pcs_model partner (.mclk(mclk), .rst_n(rst_n), .linkReq(linkReq), .txReq(txReq),
    .ctrlIn(ctrlOut), .pcsStatus(pcsStatus), .macTxEnable(macTxEnable));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(negedge mclk) begin
    if (ctrlOut.autonegRestart === 1'b1) restarts++;
    if (ctrlOut.fiberLogicReset === 1'b1) resetCycles++;
  end
  // ****************
  // tasks
  // ****************
  task results;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e, input string m);
    begin
      checks++;
      if (g !== e) begin
        miscompares++;
        $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
      end
    end
  endtask
  task timeout;
    begin
      miscompares++;
      $display("wrong value at %0t: no answer", $time);
      results();
    end
  endtask
  task axw(input logic [13:0] a, input logic [15:0] d, input logic [1:0] er);
    logic aw, w, b;
    int n;
    begin
      @(posedge mclk);
      awAddr <= a;
      wData <= {16'h0000, d};
      wStrb <= 4'h3;
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      b = 1'b0;
      n = 0;
      while (!b) begin
        @(negedge mclk);
        aw = awValid && awReady;
        w = wValid && wReady;
        b = bValid;
        if (b) cmp(32'(bResp), 32'(er), "bresp");
        @(posedge mclk);
        if (aw) awValid <= 1'b0;
        if (w) wValid <= 1'b0;
        if (b) bReady <= 1'b0;
        n++;
        if (n > 50) timeout();
      end
    end
  endtask
  task axr(input logic [13:0] a, input logic [15:0] e, input logic [15:0] m, input logic [1:0] er);
    logic ar, r;
    int n;
    begin
      @(posedge mclk);
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      r = 1'b0;
      n = 0;
      while (!r) begin
        @(negedge mclk);
        ar = arValid && arReady;
        r = rValid;
        if (r) cmp(rData & {16'hFFFF, m}, {16'h0000, e & m}, "rdata");
        if (r) cmp(32'(rResp), 32'(er), "rresp");
        @(posedge mclk);
        if (ar) arValid <= 1'b0;
        if (r) rReady <= 1'b0;
        n++;
        if (n > 50) timeout();
      end
    end
  endtask
  function automatic fsc_ctrl_t expCtrl(input logic [15:0] c, input logic bd, input logic ll);
    fsc_ctrl_t x;
    x = '0;
    x.macSideLoopback = c[14];
    x.linkSpeed = fsc_speed_t'({c[6], c[13]});
    x.autonegEnable = c[12];
    x.serdesPowerDown = c[11];
    x.macIsolate = c[10] & ~bd;
    x.forcedDuplex = c[8];
    x.collisionTest = c[7];
    x.sgmiiForcedSpeedHigh = c[6] & ~c[12];
    x.linkLossEnable = ~ll;
    x.sgmiiToRgmiiBridge = bd;
    return x;
  endfunction
  // ****************
  // sequence
  // ****************
  initial begin
    {rst_n, awValid, wValid, bReady, arValid, rReady, miiFxMode, linkReq, txReq} = '0;
    {awAddr, arAddr, wData, wStrb} = '0;
    strapPins = '{speedLow: 1'b1, speedHigh: 1'b0, autonegEnable: 1'b0};
    r0 = int'($urandom(32'h4D8556F3));
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    axr(FSC_ADDR_LINK_LOSS, 16'h1FFD, 16'hFFFF, FSC_RESP_OKAY);
    axr(FSC_ADDR_FIBER_CONTROL, 16'h2100, 16'hFFFF, FSC_RESP_OKAY);
    cmp(32'(ctrlOut), 32'(expCtrl(16'h2100, 1'b0, 1'b1)), "reset ctrl");
    axr(FSC_ADDR_FIBER_STATUS, FSC_RST_FIBER_STATUS, 16'hFFFF, FSC_RESP_OKAY);
    axr(14'h0100, 16'h0000, 16'hFFFF, FSC_RESP_SLVERR);
    axw(FSC_ADDR_FIBER_STATUS, 16'h0000, FSC_RESP_SLVERR);
    axw(FSC_ADDR_LINK_LOSS, 16'h1FFC, FSC_RESP_OKAY);
    repeat (2) @(posedge mclk);
    cmp(32'(ctrlOut.linkLossEnable), 32'h1, "link loss");
    for (int i = 0; i < 14; i++) begin
      br = (i < 4) ? 1'(i) : 1'($urandom);
      v = (i < 4) ? corner[i] : 16'($urandom) & 16'h7DFF;
      axw(FSC_ADDR_MODE_CFG, {15'h0000, br}, FSC_RESP_OKAY);
      axw(FSC_ADDR_FIBER_CONTROL, v, FSC_RESP_OKAY);
      repeat (2) @(posedge mclk);
      cmp(32'(ctrlOut), 32'(expCtrl(v, br, 1'b0)), "controls");
      axr(FSC_ADDR_FIBER_CONTROL, v, 16'hFFFF, FSC_RESP_OKAY);
    end
    axw(FSC_ADDR_MODE_CFG, 16'h0000, FSC_RESP_OKAY);
    linkReq <= 1'b1;
    r0 = restarts;
    axw(FSC_ADDR_FIBER_CONTROL, 16'h1200, FSC_RESP_OKAY);
    repeat (4) @(posedge mclk);
    cmp(restarts, r0 + 1, "restart pulses");
    axr(FSC_ADDR_FIBER_CONTROL, 16'h1000, 16'hFFFF, FSC_RESP_OKAY);
    repeat (60) @(posedge mclk);
    axr(FSC_ADDR_FIBER_STATUS, 16'h616D, 16'hFFFF, FSC_RESP_OKAY);
    r0 = resetCycles;
    axw(FSC_ADDR_FIBER_CONTROL, 16'h9000, FSC_RESP_OKAY);
    repeat (40) @(posedge mclk);
    cmp(32'(resetCycles - r0 >= 16), 32'h1, "reset length");
    axr(FSC_ADDR_FIBER_CONTROL, 16'h0000, 16'h8000, FSC_RESP_OKAY);
    axw(FSC_ADDR_FIBER_CONTROL, 16'h0180, FSC_RESP_OKAY);
    txReq <= 1'b1;
    repeat (8) @(posedge mclk);
    cmp(32'(collisionOut), 32'h1, "collision");
    axw(FSC_ADDR_FIBER_CONTROL, 16'h0980, FSC_RESP_OKAY);
    repeat (8) @(posedge mclk);
    cmp(32'(collisionOut), 32'h0, "collision off");
    txReq <= 1'b0;
    axw(FSC_ADDR_FIBER_CONTROL, 16'h0000, FSC_RESP_OKAY);
    miiFxMode <= 1'b1;
    repeat (8) @(posedge mclk);
    cmp(32'(duplexFull), 32'h0, "half duplex");
    miiFxMode <= 1'b0;
    repeat (8) @(posedge mclk);
    cmp(32'(duplexFull), 32'h1, "duplex unforced");
    results();
  end
endmodule
`default_nettype wire
